// ### core/fax_relay_defs.vh
// How it works
// - non-final channel NSS returns to near setup
// - channel NSC/DTC: become remodulator, far setup
// - compatible channel NSS/DCS starts originating fax
// - incompatible channel NSS/DCS releases, goes idle
// - channel PRI-type commands release, go idle
// - channel CTC takes extracted rate, kind
// - channel EOR records suffix, awaits response
// - compatible packet CTR restarts originating fax
// - incompatible packet CTR releases, goes idle
// - ERR after EOM types goes near setup
// - ERR after Null/MPS types resumes page
// - packet PIN returns to command wait
// - ERR after EOP types: voice, idle
// - compatible packet setup starts terminating fax
// - incompatible far setup releases, goes idle
// - packet NSC/DTC: become demodulator, near setup
// - incoming message during remodulator training: halt, idle
// - halt indication: voice paths, await confirm
// - cancel indication: voice paths, release, idle
// - packet DCS/NSS in confirm wait: idle
// - channel CFR starts terminating page
// - channel CRP/FTT/NSC/DTC returns far setup
`ifndef FAX_RELAY_DEFS_VH
`define FAX_RELAY_DEFS_VH
// register byte offsets
`define REG_RATE_ALLOW 4'h0
`define REG_KIND_ALLOW 4'h4
`define REG_STATE 4'h8
`define REG_STATUS 4'hC
// reset values of the allow masks
`define RATE_ALLOW_RESET 16'hFFFF
`define KIND_ALLOW_RESET 8'hFF
// field positions
`define STATE_ROLE_BIT 16
`define STATUS_DEMUX_LSB 2
`define STATUS_COUNT_LSB 4
`define STATUS_ORATE_LSB 8
`define STATUS_OKIND_LSB 12
`define STATUS_TRATE_LSB 16
`define STATUS_TKIND_LSB 20
`define STATUS_EOR_LSB 24
// path selector codes
`define PATH_VOICE 2'h0
`define PATH_FAX 2'h1
`define PATH_OFF 2'h2
// recognised control message codes
`define MSG_NSS 5'h01
`define MSG_DCS 5'h02
`define MSG_NSC 5'h03
`define MSG_DTC 5'h04
`define MSG_EOR_PRI_Q 5'h05
`define MSG_PRI_Q 5'h06
`define MSG_PPS_PRI_Q 5'h07
`define MSG_CTC 5'h08
`define MSG_EOR 5'h09
`define MSG_CTR 5'h0A
`define MSG_ERR 5'h0B
`define MSG_PIN 5'h0C
`define MSG_CFR 5'h0D
`define MSG_CRP 5'h0E
`define MSG_FTT 5'h0F
// retransmission-end suffix codes
`define EOR_NULL 3'h0
`define EOR_EOM 3'h1
`define EOR_MPS 3'h2
`define EOR_EOP 3'h3
`define EOR_PRI_EOM 3'h4
`define EOR_PRI_MPS 3'h5
`define EOR_PRI_EOP 3'h6
`endif

// ### core/fax_compat_check.v
`timescale 1ns/100ps
`default_nettype none
module fax_compat_check
#(
  parameter RATE_W = 4,
  parameter KIND_W = 3
)
(
  // extracted modem settings
  input wire [RATE_W-1:0] rate_in,
  input wire [KIND_W-1:0] kind_in,
  // resources on hand
  input wire [(1<<RATE_W)-1:0] rate_allow_in,
  input wire [(1<<KIND_W)-1:0] kind_allow_in,
  // verdict
  output wire compatible_out
);
  // a rate and a kind both have to be supported by the modem pool
  assign compatible_out = rate_allow_in[rate_in] & kind_allow_in[kind_in];
endmodule
`default_nettype wire

// ### core/fax_reg_slave.v
`timescale 1ns/100ps
`include "fax_relay_defs.vh"
`default_nettype none
module fax_reg_slave
(
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // avalon-mm slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // controller side
  input wire [31:0] state_word_in,
  input wire [31:0] status_word_in,
  output reg [15:0] rate_allow_out,
  output reg [7:0] kind_allow_out,
  output reg force_valid_out,
  output reg [9:0] force_state_out,
  output reg force_role_out
);
  reg ack;
  wire req;

  // one wait cycle: the answer lands on the second edge of a request
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack;

  // register writes and read data capture
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      rate_allow_out <= `RATE_ALLOW_RESET;
      kind_allow_out <= `KIND_ALLOW_RESET;
      force_valid_out <= 1'b0;
      force_state_out <= 10'h001;
      force_role_out <= 1'b0;
    end
    else
    begin
      ack <= req & ~ack;
      force_valid_out <= 1'b0;
      if (avs_write_in && ack)
      begin
        case (avs_address_in)
          `REG_RATE_ALLOW: rate_allow_out <= avs_writedata_in[15:0];
          `REG_KIND_ALLOW: kind_allow_out <= avs_writedata_in[7:0];
          `REG_STATE:
          begin
            force_valid_out <= 1'b1;
            force_state_out <= avs_writedata_in[9:0];
            force_role_out <= avs_writedata_in[`STATE_ROLE_BIT];
          end
          default: ;
        endcase
      end
      if (avs_read_in && !ack)
      begin
        case (avs_address_in)
          `REG_RATE_ALLOW: avs_readdata_out <= {16'h0000, rate_allow_out};
          `REG_KIND_ALLOW: avs_readdata_out <= {24'h000000, kind_allow_out};
          `REG_STATE: avs_readdata_out <= state_word_in;
          `REG_STATUS: avs_readdata_out <= status_word_in;
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### core/fax_relay_call_state_machine.v
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "fax_relay_defs.vh"
`default_nettype none
module fax_relay_call_state_machine
#(
  parameter RATE_W = 4,
  parameter KIND_W = 3,
  parameter COUNT_W = 2
)
(
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // avalon-mm register port
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // low-speed demodulator reports
  input wire msg_valid_in,
  input wire [4:0] msg_code_in,
  input wire msg_from_packet_in,
  input wire msg_final_in,
  input wire [RATE_W-1:0] msg_rate_in,
  input wire [KIND_W-1:0] msg_kind_in,
  input wire [2:0] msg_eor_type_in,
  input wire msg_incoming_in,
  // modulation layer indications
  input wire ml_halt_ind_in,
  input wire ml_cancel_ind_in,
  // modulation layer primitives out
  output reg fax_begin_out,
  output reg fax_begin_is_response_out,
  output reg [RATE_W-1:0] fax_begin_rate_out,
  output reg [KIND_W-1:0] fax_begin_kind_out,
  output reg fax_halt_response_out,
  // path control and resources
  output reg [1:0] mux_path_out,
  output reg [1:0] demux_path_out,
  output reg release_out,
  output reg remod_role_out,
  output wire [9:0] state_out
);
  // one-hot call states
  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_NEAR_SETUP = 10'h002;
  localparam [9:0] ST_CMD = 10'h004;
  localparam [9:0] ST_CORR_RETX = 10'h008;
  localparam [9:0] ST_CORR_RESP = 10'h010;
  localparam [9:0] ST_RETX_RESP = 10'h020;
  localparam [9:0] ST_PAGE_END = 10'h040;
  localparam [9:0] ST_FAR_SETUP = 10'h080;
  localparam [9:0] ST_TRAIN = 10'h100;
  localparam [9:0] ST_RX_CONFIRM = 10'h200;

  reg [9:0] state;
  reg [9:0] next_state;
  reg next_role;
  reg [1:0] next_mux;
  reg [1:0] next_demux;
  reg next_begin;
  reg next_begin_resp;
  reg [RATE_W-1:0] next_begin_rate;
  reg [KIND_W-1:0] next_begin_kind;
  reg next_halt_resp;
  reg next_release;
  reg [RATE_W-1:0] originating_modem_rate;
  reg [KIND_W-1:0] originating_modem_kind;
  reg [RATE_W-1:0] terminating_modem_rate;
  reg [KIND_W-1:0] terminating_modem_kind;
  reg [COUNT_W-1:0] partial_page_retry_count;
  reg [2:0] retx_end_type;
  reg [RATE_W-1:0] next_orig_rate;
  reg [KIND_W-1:0] next_orig_kind;
  reg [RATE_W-1:0] next_term_rate;
  reg [KIND_W-1:0] next_term_kind;
  reg [COUNT_W-1:0] next_count;
  reg [2:0] next_eor_type;
  wire compatible;
  wire [15:0] rate_allow;
  wire [7:0] kind_allow;
  wire force_valid;
  wire [9:0] force_state;
  wire force_role;
  wire [31:0] state_word;
  wire [31:0] status_word;
  wire from_channel;
  wire from_packet;

  // true when a recognised message has the given code
  function is_msg;
    input valid;
    input [4:0] code;
    input [4:0] want;
    begin
      is_msg = valid & (code == want);
    end
  endfunction

  // legal one-hot forced state
  function one_hot10;
    input [9:0] v;
    begin
      one_hot10 = (v != 10'h000) && ((v & (v - 10'h001)) == 10'h000);
    end
  endfunction

  assign from_channel = msg_valid_in & ~msg_from_packet_in;
  assign from_packet = msg_valid_in & msg_from_packet_in;
  assign state_out = state;

  // readback words for the register port
  assign state_word = {15'h0000, remod_role_out, 6'h00, state};
  assign status_word = {5'h00, retx_end_type,
                        {(4-KIND_W){1'b0}}, terminating_modem_kind,
                        {(4-RATE_W){1'b0}}, terminating_modem_rate,
                        {(4-KIND_W){1'b0}}, originating_modem_kind,
                        {(4-RATE_W){1'b0}}, originating_modem_rate,
                        {(4-COUNT_W){1'b0}}, partial_page_retry_count,
                        demux_path_out, mux_path_out};

  // register port and resource masks
  fax_reg_slave u_regs
  (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .state_word_in(state_word),
    .status_word_in(status_word),
    .rate_allow_out(rate_allow),
    .kind_allow_out(kind_allow),
    .force_valid_out(force_valid),
    .force_state_out(force_state),
    .force_role_out(force_role)
  );

  // extracted rate and kind against the modem pool
  fax_compat_check #(.RATE_W(RATE_W), .KIND_W(KIND_W)) u_compat
  (
    .rate_in(msg_rate_in),
    .kind_in(msg_kind_in),
    .rate_allow_in(rate_allow[(1<<RATE_W)-1:0]),
    .kind_allow_in(kind_allow[(1<<KIND_W)-1:0]),
    .compatible_out(compatible)
  );

  // transition and action decode
  always @*
  begin
    next_state = state;
    next_role = remod_role_out;
    next_mux = mux_path_out;
    next_demux = demux_path_out;
    next_begin = 1'b0;
    next_begin_resp = fax_begin_is_response_out;
    next_begin_rate = fax_begin_rate_out;
    next_begin_kind = fax_begin_kind_out;
    next_halt_resp = 1'b0;
    next_release = 1'b0;
    next_orig_rate = originating_modem_rate;
    next_orig_kind = originating_modem_kind;
    next_term_rate = terminating_modem_rate;
    next_term_kind = terminating_modem_kind;
    next_count = partial_page_retry_count;
    next_eor_type = retx_end_type;
    case (state)
      ST_CMD:
      begin
        if (is_msg(from_channel, msg_code_in, `MSG_NSS) && !msg_final_in)
          next_state = ST_NEAR_SETUP;
        else if (is_msg(from_channel, msg_code_in, `MSG_NSC) ||
                 is_msg(from_channel, msg_code_in, `MSG_DTC))
        begin
          next_role = 1'b1;
          next_state = ST_FAR_SETUP;
        end
        else if (is_msg(from_channel, msg_code_in, `MSG_NSS) ||
                 is_msg(from_channel, msg_code_in, `MSG_DCS))
        begin
          if (compatible)
          begin
            next_orig_rate = msg_rate_in;
            next_orig_kind = msg_kind_in;
            next_demux = `PATH_FAX;
            next_begin = 1'b1;
            next_begin_resp = 1'b0;
            next_begin_rate = msg_rate_in;
            next_begin_kind = msg_kind_in;
            next_count = {COUNT_W{1'b0}};
            next_state = ST_TRAIN;
          end
          else
          begin
            next_release = 1'b1;
            next_state = ST_IDLE;
          end
        end
        else if (is_msg(from_channel, msg_code_in, `MSG_EOR_PRI_Q) ||
                 is_msg(from_channel, msg_code_in, `MSG_PRI_Q) ||
                 is_msg(from_channel, msg_code_in, `MSG_PPS_PRI_Q))
        begin
          next_release = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_CORR_RETX:
      begin
        if (is_msg(from_channel, msg_code_in, `MSG_CTC))
        begin
          next_orig_rate = msg_rate_in;
          next_orig_kind = msg_kind_in;
          next_state = ST_CORR_RESP;
        end
        else if (is_msg(from_channel, msg_code_in, `MSG_EOR))
        begin
          next_eor_type = msg_eor_type_in;
          next_state = ST_RETX_RESP;
        end
      end
      ST_CORR_RESP:
      begin
        if (is_msg(from_packet, msg_code_in, `MSG_CTR))
        begin
          if (compatible)
          begin
            next_orig_rate = msg_rate_in;
            next_orig_kind = msg_kind_in;
            next_demux = `PATH_FAX;
            next_begin = 1'b1;
            next_begin_resp = 1'b0;
            next_begin_rate = msg_rate_in;
            next_begin_kind = msg_kind_in;
            next_count = {COUNT_W{1'b0}};
            next_state = ST_PAGE_END;
          end
          else
          begin
            next_release = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_RETX_RESP:
      begin
        if (is_msg(from_packet, msg_code_in, `MSG_ERR))
        begin
          case (retx_end_type)
            `EOR_EOM, `EOR_PRI_EOM:
              next_state = ST_NEAR_SETUP;
            `EOR_NULL, `EOR_MPS, `EOR_PRI_MPS:
            begin
              next_demux = `PATH_FAX;
              next_begin = 1'b1;
              next_begin_resp = 1'b0;
              next_begin_rate = originating_modem_rate;
              next_begin_kind = originating_modem_kind;
              next_state = ST_PAGE_END;
            end
            `EOR_EOP, `EOR_PRI_EOP:
            begin
              next_mux = `PATH_VOICE;
              next_demux = `PATH_VOICE;
              next_release = 1'b1;
              next_state = ST_IDLE;
            end
            default: ;
          endcase
        end
        else if (is_msg(from_packet, msg_code_in, `MSG_PIN))
          next_state = ST_CMD;
      end
      ST_FAR_SETUP:
      begin
        if (is_msg(from_packet, msg_code_in, `MSG_NSS) ||
            is_msg(from_packet, msg_code_in, `MSG_DCS))
        begin
          if (compatible)
          begin
            next_term_rate = msg_rate_in;
            next_term_kind = msg_kind_in;
            next_mux = `PATH_FAX;
            next_demux = `PATH_OFF;
            next_begin = 1'b1;
            next_begin_resp = 1'b1;
            next_begin_rate = msg_rate_in;
            next_begin_kind = msg_kind_in;
            next_count = {COUNT_W{1'b0}};
            next_state = ST_TRAIN;
          end
          else
          begin
            next_release = 1'b1;
            next_state = ST_IDLE;
          end
        end
        else if (is_msg(from_packet, msg_code_in, `MSG_NSC) ||
                 is_msg(from_packet, msg_code_in, `MSG_DTC))
        begin
          next_role = 1'b0;
          next_state = ST_NEAR_SETUP;
        end
      end
      ST_TRAIN:
      begin
        if (remod_role_out)
        begin
          if (msg_incoming_in)
          begin
            next_mux = `PATH_VOICE;
            next_demux = `PATH_VOICE;
            next_halt_resp = 1'b1;
            next_release = 1'b1;
            next_state = ST_IDLE;
          end
          else if (ml_halt_ind_in)
          begin
            next_mux = `PATH_VOICE;
            next_demux = `PATH_VOICE;
            next_state = ST_RX_CONFIRM;
          end
          else if (ml_cancel_ind_in)
          begin
            next_mux = `PATH_VOICE;
            next_demux = `PATH_VOICE;
            next_release = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_RX_CONFIRM:
      begin
        if (is_msg(from_packet, msg_code_in, `MSG_NSS) ||
            is_msg(from_packet, msg_code_in, `MSG_DCS))
        begin
          next_mux = `PATH_VOICE;
          next_demux = `PATH_VOICE;
          next_release = 1'b1;
          next_state = ST_IDLE;
        end
        else if (is_msg(from_channel, msg_code_in, `MSG_CFR))
        begin
          next_mux = `PATH_FAX;
          next_demux = `PATH_OFF;
          next_begin = 1'b1;
          next_begin_resp = 1'b1;
          next_begin_rate = terminating_modem_rate;
          next_begin_kind = terminating_modem_kind;
          next_state = ST_PAGE_END;
        end
        else if (is_msg(from_channel, msg_code_in, `MSG_CRP) ||
                 is_msg(from_channel, msg_code_in, `MSG_FTT) ||
                 is_msg(from_channel, msg_code_in, `MSG_NSC) ||
                 is_msg(from_channel, msg_code_in, `MSG_DTC))
          next_state = ST_FAR_SETUP;
      end
      // idle, near setup and page end belong to a sibling controller
      default: ;
    endcase
    // software placement wins so a sibling hand-off is never lost
    if (force_valid && one_hot10(force_state))
    begin
      next_state = force_state;
      next_role = force_role;
    end
  end

  // state, variables and primitive outputs
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_IDLE;
      remod_role_out <= 1'b0;
      mux_path_out <= `PATH_VOICE;
      demux_path_out <= `PATH_VOICE;
      fax_begin_out <= 1'b0;
      fax_begin_is_response_out <= 1'b0;
      fax_begin_rate_out <= {RATE_W{1'b0}};
      fax_begin_kind_out <= {KIND_W{1'b0}};
      fax_halt_response_out <= 1'b0;
      release_out <= 1'b0;
      originating_modem_rate <= {RATE_W{1'b0}};
      originating_modem_kind <= {KIND_W{1'b0}};
      terminating_modem_rate <= {RATE_W{1'b0}};
      terminating_modem_kind <= {KIND_W{1'b0}};
      partial_page_retry_count <= {COUNT_W{1'b0}};
      retx_end_type <= `EOR_NULL;
    end
    else
    begin
      state <= next_state;
      remod_role_out <= next_role;
      mux_path_out <= next_mux;
      demux_path_out <= next_demux;
      fax_begin_out <= next_begin;
      fax_begin_is_response_out <= next_begin_resp;
      fax_begin_rate_out <= next_begin_rate;
      fax_begin_kind_out <= next_begin_kind;
      fax_halt_response_out <= next_halt_resp;
      release_out <= next_release;
      originating_modem_rate <= next_orig_rate;
      originating_modem_kind <= next_orig_kind;
      terminating_modem_rate <= next_term_rate;
      terminating_modem_kind <= next_term_kind;
      partial_page_retry_count <= next_count;
      retx_end_type <= next_eor_type;
    end
  end
endmodule
`default_nettype wire

// ### verif/fax_ml_model.sv
`timescale 1ns/100ps
`default_nettype none
module fax_ml_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // begin primitive seen, bench controls
  input wire logic begin_in,
  input wire logic [1:0] mode_in,
  input wire logic [3:0] dly_in,
  // indications back to the block
  output logic halt_out,
  output logic cancel_out
);
  logic [3:0] cnt;
  // mode 1 halt, mode 2 cancel, dly_in after begin
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt <= 4'h0;
      halt_out <= 1'b0;
      cancel_out <= 1'b0;
    end
    else
    begin
      halt_out <= cnt == 4'h1 && mode_in == 2'h1;
      cancel_out <= cnt == 4'h1 && mode_in == 2'h2;
      cnt <= (begin_in && mode_in != 2'h0) ? dly_in : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
    end
  end
endmodule
`default_nettype wire

// ### verif/fax_relay_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fax_relay_properties (
  // clock, reset, strobes
  input wire ref_clk_in, nrst_in, avs_write_in, msg_valid_in, msg_from_packet_in,
  input wire msg_final_in, msg_incoming_in, ml_halt_ind_in, ml_cancel_ind_in,
  input wire [4:0] msg_code_in,
  // primitives and paths
  input wire fax_begin_out, fax_begin_is_response_out, fax_halt_response_out,
  input wire release_out, remod_role_out,
  input wire [1:0] mux_path_out, demux_path_out,
  input wire [9:0] state_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // side-qualified reports
  wire ch = msg_valid_in & !msg_from_packet_in;
  wire pk = msg_valid_in & msg_from_packet_in;
  wire [9:0] s = state_out;
  wire tr = s == 10'h100 && remod_role_out;
  wire vo = mux_path_out == 2'h0 && demux_path_out == 2'h0;
  chk_nonfinal_near: assert property (
    s == 10'h004 && ch && msg_code_in == 5'h01 && !msg_final_in |=> s == 10'h002)
    else $error("nonfinal");
  chk_role_swap: assert property (
    s == 10'h004 && ch && (msg_code_in == 5'h03 || msg_code_in == 5'h04)
    |=> s == 10'h080 && remod_role_out) else $error("swap");
  chk_pri_release: assert property (
    s == 10'h004 && ch && msg_code_in >= 5'h05 && msg_code_in <= 5'h07
    |=> s == 10'h001 && release_out) else $error("pri");
  chk_pin_back: assert property (
    s == 10'h020 && pk && msg_code_in == 5'h0C |=> s == 10'h004) else $error("pin lost");
  chk_incoming_halt: assert property (
    tr && msg_incoming_in |=> s == 10'h001 && fax_halt_response_out && vo)
    else $error("incoming");
  chk_halt_confirm: assert property (
    tr && ml_halt_ind_in && !msg_incoming_in |=> s == 10'h200 && vo) else $error("halt");
  chk_cancel_idle: assert property (
    tr && ml_cancel_ind_in && !ml_halt_ind_in && !msg_incoming_in |=> s == 10'h001 && vo)
    else $error("cancel");
  chk_cfr_page: assert property (
    s == 10'h200 && ch && msg_code_in == 5'h0D |=> s == 10'h040 && fax_begin_out
    && fax_begin_is_response_out && mux_path_out == 2'h1 && demux_path_out == 2'h2)
    else $error("cfr");
  chk_quiet_hold: assert property (
    !msg_valid_in && !msg_incoming_in && !ml_halt_ind_in && !ml_cancel_ind_in && !avs_write_in
    && !$past(avs_write_in) |=> $stable(s))
    else $error("quiet");
  cover property (s == 10'h200 ##1 s == 10'h040);
  cover property (s == 10'h020 && pk);
  cover property (fax_halt_response_out);
endmodule
bind fax_relay_call_state_machine fax_relay_properties u_chk (.*);
`default_nettype wire

// ### verif/tb_fax_relay_call_state_machine.sv
`timescale 1ns/100ps
`include "fax_relay_defs.vh"
`default_nettype none
module tb_fax_relay_call_state_machine;
  logic clk = 0, rst_n = 0, mv = 0, mp = 0, mf = 1, mi = 0, rd_s = 0, wr_s = 0;
  logic [4:0] mc = 0;
  logic [3:0] mr = 0, ad = 0, pd = 1;
  logic [2:0] mk = 0, me = 0;
  logic [1:0] pm = 0;
  logic [31:0] wd = 0, q;
  wire [31:0] rdat;
  wire wq, fb, fbr, fh, rel, rl, hi, ci;
  wire [3:0] fr;
  wire [2:0] fk;
  wire [1:0] mx, dx;
  wire [9:0] st;
  integer error_cnt = 0, n_checks = 0;
  // block and modulation layer model
  fax_relay_call_state_machine u_dut (.ref_clk_in(clk), .nrst_in(rst_n),
    .avs_address_in(ad), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .msg_valid_in(mv), .msg_code_in(mc),
    .msg_from_packet_in(mp), .msg_final_in(mf), .msg_rate_in(mr), .msg_kind_in(mk),
    .msg_eor_type_in(me), .msg_incoming_in(mi), .ml_halt_ind_in(hi), .ml_cancel_ind_in(ci),
    .fax_begin_out(fb), .fax_begin_is_response_out(fbr), .fax_begin_rate_out(fr),
    .fax_begin_kind_out(fk), .fax_halt_response_out(fh), .mux_path_out(mx),
    .demux_path_out(dx), .release_out(rel), .remod_role_out(rl), .state_out(st));
  fax_ml_model u_ml (.ref_clk_in(clk), .nrst_in(rst_n), .begin_in(fb), .mode_in(pm),
    .dly_in(pd), .halt_out(hi), .cancel_out(ci));
  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  task ck(input [31:0] s, input [31:0] x);
    begin
      n_checks++;
      if (s !== x)
        error_cnt++;
      if (s !== x)
        $display("Error t=%0t seen %h exp %h", $time, s, x);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task bus(input wr, input [3:0] a, input [31:0] v);
    integer i;
    begin
      @(posedge clk);
      {ad, wd, wr_s, rd_s} <= {a, v, wr, !wr};
      @(posedge clk);
      for (i = 0; i < 20 && wq !== 1'b0; i++)
        @(posedge clk);
      q = rdat;
      {rd_s, wr_s} <= 2'h0;
      if (i == 20)
        error_cnt++;
      if (i == 20)
        stop_test;
    end
  endtask
  // one report pulse, checked after taking
  task m(input [4:0] c, input p, input f, input [3:0] r, input [2:0] k, input [2:0] e);
    begin
      @(posedge clk);
      {mc, mp, mf, mr, mk, me, mv} <= {c, p, f, r, k, e, 1'b1};
      @(posedge clk);
      mv <= 1'b0;
      @(negedge clk);
    end
  endtask
  task wt(input [9:0] x);
    integer i;
    begin
      for (i = 0; i < 40 && st !== x; i++)
        @(negedge clk);
      ck(st, x);
      if (i == 40)
        stop_test;
    end
  endtask
  // reset values, unmapped places
  task t_regs;
    begin
      bus(0, `REG_KIND_ALLOW, 0);
      ck(q, 32'h000000FF);
      bus(0, `REG_STATE, 0);
      ck(q, 32'h00000001);
      bus(1, 4'h2, 32'hFFFFFFFF);
      bus(1, `REG_STATUS, 32'hFFFFFFFF);
      bus(0, 4'h2, 0);
      ck(q, 0);
      bus(0, `REG_STATUS, 0);
      ck(q, 0);
      bus(0, `REG_RATE_ALLOW, 0);
      ck(q, 32'h0000FFFF);
    end
  endtask
  // demodulating command wait
  task t_cmd;
    integer j;
    begin
      bus(1, `REG_STATE, 32'h004);
      m(`MSG_NSS, 0, 0, 5, 2, 0);
      ck(st, 10'h002);
      for (j = 3; j < 8; j++)
      begin
        bus(1, `REG_STATE, 32'h004);
        m(j[4:0], 0, 1, 0, 0, 0);
        ck({rel, rl, st}, j < 5 ? 12'h480 : 12'h801);
        m(j[4:0], 1, 1, 0, 0, 0);
        if (j < 5)
          ck({rl, st}, 11'h002);
      end
      bus(1, `REG_STATE, 32'h004);
      m(`MSG_CFR, 0, 1, 0, 0, 0);
      ck(st, 10'h004);
      m(`MSG_DCS, 0, 1, 5, 2, 0);
      ck({fb, fbr, fr, fk, dx, st}, {2'h2, 4'h5, 3'h2, 2'h1, 10'h100});
      bus(0, `REG_STATUS, 0);
      ck({q[14:8], q[5:2]}, {7'h25, 4'h1});
      bus(1, `REG_RATE_ALLOW, 32'hFFDF);
      bus(1, `REG_STATE, 32'h004);
      m(`MSG_NSS, 0, 1, 5, 2, 0);
      ck({rel, st}, 11'h401);
      bus(1, `REG_RATE_ALLOW, 32'hFFFF);
    end
  endtask
  // remodulating far setup, training, confirm
  task t_far;
    integer j;
    begin
      {pm, pd} <= {2'h1, 4'h1};
      bus(1, `REG_STATE, 32'h10080);
      m(`MSG_DCS, 1, 1, 3, 1, 0);
      ck({fb, fbr, fr, fk, mx, dx, st}, {2'h3, 4'h3, 3'h1, 4'h6, 10'h100});
      wt(10'h200);
      ck({mx, dx}, 0);
      m(`MSG_CFR, 0, 1, 0, 0, 0);
      ck({fb, fbr, fr, fk, mx, dx, st}, {2'h3, 4'h3, 3'h1, 4'h6, 10'h040});
      {pm, pd} <= {2'h2, 4'h9};
      bus(1, `REG_STATE, 32'h10080);
      m(`MSG_NSS, 1, 1, 3, 1, 0);
      wt(10'h001);
      pm <= 2'h0;
      bus(1, `REG_STATE, 32'h10080);
      m(`MSG_DCS, 1, 1, 3, 1, 0);
      @(posedge clk);
      mi <= 1'b1;
      @(posedge clk);
      mi <= 1'b0;
      @(negedge clk);
      ck({fh, mx, dx, st}, 15'h4001);
      bus(1, `REG_KIND_ALLOW, 32'hFD);
      bus(1, `REG_STATE, 32'h10080);
      m(`MSG_DCS, 1, 1, 3, 1, 0);
      ck(st, 10'h001);
      bus(1, `REG_KIND_ALLOW, 32'hFF);
      bus(1, `REG_STATE, 32'h10200);
      m(`MSG_DCS, 1, 1, 0, 0, 0);
      ck({mx, dx, st}, 14'h0001);
      for (j = 0; j < 4; j++)
      begin
        bus(1, `REG_STATE, 32'h10200);
        m(j < 2 ? 5'h0E + j[4:0] : 5'h01 + j[4:0], 0, 1, 0, 0, 0);
        ck(st, 10'h080);
      end
    end
  endtask
  // correction and retransmission end
  task t_ecm;
    integer j;
    logic [9:0] x;
    begin
      bus(1, `REG_STATE, 32'h008);
      m(`MSG_CTC, 0, 1, 7, 4, 0);
      ck(st, 10'h010);
      bus(0, `REG_STATUS, 0);
      ck(q[14:8], 7'h47);
      m(`MSG_CTR, 1, 1, 2, 3, 0);
      ck({fb, fbr, fr, fk, dx, st}, {2'h2, 4'h2, 3'h3, 2'h1, 10'h040});
      bus(1, `REG_KIND_ALLOW, 32'hF7);
      bus(1, `REG_STATE, 32'h010);
      m(`MSG_CTR, 1, 1, 2, 3, 0);
      ck({rel, st}, 11'h401);
      bus(1, `REG_KIND_ALLOW, 32'hFF);
      for (j = 0; j < 7; j++)
      begin
        x = (j == 1 || j == 4) ? 10'h002 : ((j == 3 || j == 6) ? 10'h001 : 10'h040);
        bus(1, `REG_STATE, 32'h008);
        m(`MSG_EOR, 0, 1, 0, 0, j[2:0]);
        bus(0, `REG_STATUS, 0);
        ck({st, q[26:24]}, {10'h020, j[2:0]});
        m(`MSG_ERR, 1, 1, 0, 0, 0);
        ck(st, x);
        if (x == 10'h040)
          ck({fb, fr, fk, dx}, {1'b1, 4'h2, 3'h3, 2'h1});
        if (x == 10'h001)
          ck({mx, dx}, 0);
      end
      m(`MSG_PIN, 1, 1, 0, 0, 0);
      ck(st, 10'h001);
      bus(1, `REG_STATE, 32'h020);
      m(`MSG_PIN, 1, 1, 0, 0, 0);
      ck(st, 10'h004);
    end
  endtask
  // reset, then every scenario
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cmd;
    t_far;
    t_ecm;
    stop_test;
  end
endmodule
`default_nettype wire
